// ==== hw/tsq_data_regs.sv ====
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module tsq_data_regs
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // APB slave
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Sequencer core
  input  wire logic        seq_busy_in,
  input  wire logic        cmd_valid_in,
  input  wire logic [2:0]  cmd_op_in,
  input  wire logic [2:0]  cmd_target_in,
  input  wire logic [4:0]  jump_target_in,
  input  wire logic [4:0]  queue_pointer_in,
  input  wire logic [15:0] timer0_count_in,
  input  wire logic [15:0] timer1_count_in,
  input  wire logic [15:0] step_delay_count_in,
  // Values to the core
  output logic      [31:0] broadcast_trig_out,
  output logic             queue_pointer_load_out,
  output logic      [4:0]  queue_pointer_next_out,
  output logic      [15:0] timer0_limit_out,
  output logic      [15:0] timer1_limit_out,
  output logic      [15:0] step_delay_limit_out,
  output logic      [15:0] counter0_limit_out,
  output logic      [15:0] counter1_limit_out,
  output logic      [15:0] literal_register_out,
  output logic      [15:0] loop_counter0_out,
  output logic      [15:0] loop_counter1_out
);

  tsq_pkg::tsq_state_type state;
  logic [15:0] dreg [tsq_pkg::REG_COUNT];
  logic        count_visibility_bit;
  logic [15:0] literal_register;
  logic [4:0]  acc_dec;
  logic        acc_hit;
  logic [3:0]  acc_idx;
  logic        setup_ph;
  logic        access_ph;
  logic        wr_fire;
  logic        sw_wr_data;
  logic        cmd_copy;
  logic        cmd_add;
  logic        cmd_jmp0;
  logic        cmd_jmp1;
  logic        cmd_bcast;
  logic        tgt_is_lit;
  logic [3:0]  tgt_idx;
  logic [15:0] target_cur;
  logic [15:0] next_target_val;
  logic [15:0] rd_val;

  tsq_cnt_if cnt_bus [tsq_pkg::LOOP_CNT] ();

  // Address decode to hit flag and index
  function automatic logic [4:0] tsq_decode(input logic [7:0] addr);
    case (addr)
      tsq_pkg::OFS_BTE_LO: tsq_decode = {1'b1, tsq_pkg::IDX_BTE_LO};
      tsq_pkg::OFS_BTE_HI: tsq_decode = {1'b1, tsq_pkg::IDX_BTE_HI};
      tsq_pkg::OFS_HOLD:   tsq_decode = {1'b1, tsq_pkg::IDX_HOLD};
      tsq_pkg::OFS_T0LIM:  tsq_decode = {1'b1, tsq_pkg::IDX_T0LIM};
      tsq_pkg::OFS_T1LIM:  tsq_decode = {1'b1, tsq_pkg::IDX_T1LIM};
      tsq_pkg::OFS_SDLIM:  tsq_decode = {1'b1, tsq_pkg::IDX_SDLIM};
      tsq_pkg::OFS_C0LIM:  tsq_decode = {1'b1, tsq_pkg::IDX_C0LIM};
      tsq_pkg::OFS_C1LIM:  tsq_decode = {1'b1, tsq_pkg::IDX_C1LIM};
      tsq_pkg::OFS_ADJ:    tsq_decode = {1'b1, tsq_pkg::IDX_ADJ};
      tsq_pkg::OFS_CTRL:   tsq_decode = {1'b1, tsq_pkg::IDX_CTRL};
      default:             tsq_decode = {1'b0, tsq_pkg::IDX_BTE_LO};
    endcase
  endfunction

  // Step target code to register index
  function automatic logic [3:0] tsq_tgt_index(input logic [2:0] tgt);
    case (tgt)
      tsq_pkg::TSQ_TGT_T0: tsq_tgt_index = tsq_pkg::IDX_T0LIM;
      tsq_pkg::TSQ_TGT_T1: tsq_tgt_index = tsq_pkg::IDX_T1LIM;
      tsq_pkg::TSQ_TGT_SD: tsq_tgt_index = tsq_pkg::IDX_SDLIM;
      tsq_pkg::TSQ_TGT_C0: tsq_tgt_index = tsq_pkg::IDX_C0LIM;
      tsq_pkg::TSQ_TGT_C1: tsq_tgt_index = tsq_pkg::IDX_C1LIM;
      default:             tsq_tgt_index = tsq_pkg::IDX_CTRL;
    endcase
  endfunction

  assign acc_dec    = tsq_decode(paddr_in);
  assign acc_hit    = acc_dec[4];
  assign acc_idx    = acc_dec[3:0];
  assign setup_ph   = psel_in && !penable_in && (state == tsq_pkg::TSQ_ST_IDLE);
  assign access_ph  = psel_in && penable_in && (state == tsq_pkg::TSQ_ST_ACK);
  assign wr_fire    = access_ph && pwrite_in && acc_hit;
  assign sw_wr_data = wr_fire && (acc_idx != tsq_pkg::IDX_CTRL) && !seq_busy_in;

  assign cmd_copy  = cmd_valid_in && (cmd_op_in == tsq_pkg::TSQ_CMD_COPY);
  assign cmd_add   = cmd_valid_in && (cmd_op_in == tsq_pkg::TSQ_CMD_ADD);
  assign cmd_jmp0  = cmd_valid_in && (cmd_op_in == tsq_pkg::TSQ_CMD_JMPC0);
  assign cmd_jmp1  = cmd_valid_in && (cmd_op_in == tsq_pkg::TSQ_CMD_JMPC1);
  assign cmd_bcast = cmd_valid_in && (cmd_op_in == tsq_pkg::TSQ_CMD_BCAST);

  assign tgt_is_lit = (cmd_target_in == tsq_pkg::TSQ_TGT_LIT);
  assign tgt_idx    = tsq_tgt_index(cmd_target_in);

  // Current target value and copy or add result
  always_comb
  begin
    if (tgt_is_lit)
      target_cur = literal_register;
    else if (tgt_idx < tsq_pkg::IDX_CTRL)
      target_cur = dreg[tgt_idx];
    else
      target_cur = tsq_pkg::DATA_RST;
    if (cmd_copy)
      next_target_val = dreg[tsq_pkg::IDX_HOLD];
    else
      next_target_val = 16'(target_cur + dreg[tsq_pkg::IDX_ADJ]);
  end

  // APB handshake state
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      state <= tsq_pkg::TSQ_ST_IDLE;
    else
      case (state)
        tsq_pkg::TSQ_ST_IDLE: if (setup_ph) state <= tsq_pkg::TSQ_ST_ACK;
        tsq_pkg::TSQ_ST_ACK:  state <= tsq_pkg::TSQ_ST_IDLE;
        default:              state <= tsq_pkg::TSQ_ST_IDLE;
      endcase
  end

  // Ready and error for the access phase
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out  <= setup_ph;
      pslverr_out <= setup_ph && !acc_hit;
    end
  end

  // Read value with optional live counts
  always_comb
  begin
    rd_val = tsq_pkg::DATA_RST;
    if (acc_idx == tsq_pkg::IDX_CTRL)
    begin
      rd_val[tsq_pkg::CTRL_VIS_BIT]  = count_visibility_bit;
      rd_val[tsq_pkg::CTRL_BUSY_BIT] = seq_busy_in;
    end
    else if (count_visibility_bit && acc_idx == tsq_pkg::IDX_T0LIM)
      rd_val = timer0_count_in;
    else if (count_visibility_bit && acc_idx == tsq_pkg::IDX_T1LIM)
      rd_val = timer1_count_in;
    else if (count_visibility_bit && acc_idx == tsq_pkg::IDX_SDLIM)
      rd_val = step_delay_count_in;
    else if (count_visibility_bit && acc_idx == tsq_pkg::IDX_C0LIM)
      rd_val = cnt_bus[0].count;
    else if (count_visibility_bit && acc_idx == tsq_pkg::IDX_C1LIM)
      rd_val = cnt_bus[1].count;
    else if (acc_idx < tsq_pkg::IDX_CTRL)
      rd_val = dreg[acc_idx];
  end

  // Read data captured in the setup cycle
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      prdata_out <= 32'h0000_0000;
    else if (setup_ph)
      prdata_out <= (acc_hit && !pwrite_in) ? {16'h0000, rd_val} : 32'h0000_0000;
  end

  // Data and limit registers
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      for (int i = 0; i < tsq_pkg::REG_COUNT; i++)
        dreg[i] <= tsq_pkg::DATA_RST;
    end
    else
    begin
      if (sw_wr_data)
        dreg[acc_idx] <= pwdata_in[15:0];
      if ((cmd_copy || cmd_add) && !tgt_is_lit && tgt_idx < tsq_pkg::IDX_CTRL)
        dreg[tgt_idx] <= next_target_val;
    end
  end

  // Literal register target
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      literal_register <= tsq_pkg::DATA_RST;
    else if ((cmd_copy || cmd_add) && tgt_is_lit)
      literal_register <= next_target_val;
  end

  // Visibility control bit
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      count_visibility_bit <= 1'b0;
    else if (wr_fire && acc_idx == tsq_pkg::IDX_CTRL)
      count_visibility_bit <= pwdata_in[tsq_pkg::CTRL_VIS_BIT];
  end

  // Loop counters
  assign cnt_bus[0].step  = cmd_jmp0;
  assign cnt_bus[1].step  = cmd_jmp1;
  assign cnt_bus[0].limit = dreg[tsq_pkg::IDX_C0LIM];
  assign cnt_bus[1].limit = dreg[tsq_pkg::IDX_C1LIM];

  genvar g;
  generate
    for (g = 0; g < tsq_pkg::LOOP_CNT; g++)
    begin : g_loop
      assign cnt_bus[g].clear = !seq_busy_in;
      tsq_loop_counter u_cnt
      (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .cnt_bus    (cnt_bus[g])
      );
    end
  endgenerate

  // Queue pointer on jump-on-counter
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      queue_pointer_load_out <= 1'b0;
      queue_pointer_next_out <= 5'h00;
    end
    else
    begin
      queue_pointer_load_out <= cmd_jmp0 || cmd_jmp1;
      if ((cmd_jmp0 && !cnt_bus[0].at_limit) || (cmd_jmp1 && !cnt_bus[1].at_limit))
        queue_pointer_next_out <= jump_target_in;
      else if (cmd_jmp0 || cmd_jmp1)
        queue_pointer_next_out <= 5'(queue_pointer_in + tsq_pkg::QPTR_STEP);
    end
  end

  tsq_bcast_trig u_bcast
  (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .fire_in    (cmd_bcast),
    .mask_in    ({dreg[tsq_pkg::IDX_BTE_HI], dreg[tsq_pkg::IDX_BTE_LO]}),
    .trig_out   (broadcast_trig_out)
  );

  assign timer0_limit_out     = dreg[tsq_pkg::IDX_T0LIM];
  assign timer1_limit_out     = dreg[tsq_pkg::IDX_T1LIM];
  assign step_delay_limit_out = dreg[tsq_pkg::IDX_SDLIM];
  assign counter0_limit_out   = dreg[tsq_pkg::IDX_C0LIM];
  assign counter1_limit_out   = dreg[tsq_pkg::IDX_C1LIM];
  assign literal_register_out = literal_register;
  assign loop_counter0_out    = cnt_bus[0].count;
  assign loop_counter1_out    = cnt_bus[1].count;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_ro_hold_busy : assert property (
    wr_fire && seq_busy_in && acc_idx == tsq_pkg::IDX_HOLD && !cmd_valid_in
    |=> $stable(dreg[tsq_pkg::IDX_HOLD]))
    else $error("hold register changed by write while busy");
  a_ro_no_error : assert property (
    setup_ph && acc_hit && seq_busy_in |=> pready_out && !pslverr_out)
    else $error("blocked write signalled an error");
  a_idle_write : assert property (
    wr_fire && !seq_busy_in && acc_idx == tsq_pkg::IDX_T1LIM
    |=> timer1_limit_out == $past(pwdata_in[15:0]))
    else $error("timer1 limit not loaded by write");
  a_copy_hold : assert property (
    cmd_copy && cmd_target_in == tsq_pkg::TSQ_TGT_T0
    |=> timer0_limit_out == $past(dreg[tsq_pkg::IDX_HOLD]))
    else $error("copy did not move hold value");
  a_add_adjust : assert property (
    cmd_add && tgt_is_lit
    |=> literal_register_out == 16'($past(literal_register) + $past(dreg[tsq_pkg::IDX_ADJ])))
    else $error("add result wrong");
  a_step_delay : assert property (
    cmd_copy && cmd_target_in == tsq_pkg::TSQ_TGT_SD
    ##1 (!cmd_valid_in && !sw_wr_data) [*2] |-> step_delay_limit_out == $past(dreg[tsq_pkg::IDX_HOLD], 2))
    else $error("step delay limit not kept");
  a_vis_read : assert property (
    setup_ph && !pwrite_in && count_visibility_bit && acc_idx == tsq_pkg::IDX_T0LIM
    |=> prdata_out == {16'h0000, $past(timer0_count_in)})
    else $error("visible read did not return timer count");
  a_lim_read : assert property (
    setup_ph && !pwrite_in && !count_visibility_bit && acc_idx == tsq_pkg::IDX_C1LIM
    |=> prdata_out == {16'h0000, $past(counter1_limit_out)})
    else $error("limit read wrong");
  a_jump_below : assert property (
    cmd_jmp0 && !cnt_bus[0].at_limit
    |=> queue_pointer_load_out && queue_pointer_next_out == $past(jump_target_in))
    else $error("jump below limit did not load target");
  a_jump_at_lim : assert property (
    cmd_jmp1 && cnt_bus[1].at_limit
    |=> queue_pointer_load_out && queue_pointer_next_out == 5'($past(queue_pointer_in) + tsq_pkg::QPTR_STEP))
    else $error("jump at limit did not advance pointer");
  a_ro_mask_busy : assert property (
    wr_fire && seq_busy_in && acc_idx == tsq_pkg::IDX_BTE_HI && !cmd_valid_in
    |=> $stable(dreg[tsq_pkg::IDX_BTE_HI]))
    else $error("mask high changed by write while busy");
  a_ro_adj_busy : assert property (
    wr_fire && seq_busy_in && acc_idx == tsq_pkg::IDX_ADJ && !cmd_valid_in
    |=> $stable(dreg[tsq_pkg::IDX_ADJ]))
    else $error("adjust changed by write while busy");
  a_ro_limit_busy : assert property (
    wr_fire && seq_busy_in && acc_idx == tsq_pkg::IDX_C0LIM && !cmd_valid_in
    |=> $stable(counter0_limit_out))
    else $error("counter0 limit changed by write while busy");
  a_vis_cnt_read : assert property (
    setup_ph && !pwrite_in && count_visibility_bit && acc_idx == tsq_pkg::IDX_C0LIM
    |=> prdata_out == {16'h0000, $past(loop_counter0_out)})
    else $error("visible read did not return loop count");
  a_qptr_quiet : assert property (
    !cmd_jmp0 && !cmd_jmp1 |=> !queue_pointer_load_out)
    else $error("queue pointer loaded without jump");
  a_cnt_idle_clr : assert property (
    !seq_busy_in |=> loop_counter0_out == tsq_pkg::DATA_RST && loop_counter1_out == tsq_pkg::DATA_RST)
    else $error("loop counters not cleared while idle");

  c_copy_cmd  : cover property (cmd_copy ##1 cmd_add);
  c_busy_wr   : cover property (wr_fire && seq_busy_in);
  c_loop_done : cover property (cmd_jmp0 && cnt_bus[0].at_limit);
  c_vis_read  : cover property (access_ph && !pwrite_in && count_visibility_bit);
  c_vis_count : cover property (setup_ph && count_visibility_bit && acc_idx == tsq_pkg::IDX_C0LIM);
endmodule

// ==== hw/tsq_pkg.sv ====
// Operation
// - 32-bit broadcast mask in low and high halves; set bits trigger their outputs
// - Mask, hold, adjust and all limit registers are read-only while steps execute
// - Copy step moves the 16-bit hold value unchanged into the chosen target
// - Add step sums the 16-bit adjust value into the chosen target
// - 16-bit step delay limit sets extra cycles before a step completes
// - Counter 0 limit is loop count of jump-on-counter-0 and counter 0 limit
// - Counter 1 limit is loop count of jump-on-counter-1 and counter 1 limit
// - Two timers, each with its own 16-bit software-loaded limit register
// - Visibility bit set makes limit reads return the matching current count
// - Jump on counter below limit increments it and jumps; at limit advances pointer
package tsq_pkg;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned MASK_W    = 32;
  localparam int unsigned QPTR_W    = 5;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned REG_COUNT = 9;
  localparam int unsigned LOOP_CNT  = 2;

  // Register byte offsets
  localparam logic [7:0] OFS_BTE_LO = 8'h00;
  localparam logic [7:0] OFS_BTE_HI = 8'h04;
  localparam logic [7:0] OFS_HOLD   = 8'h08;
  localparam logic [7:0] OFS_T0LIM  = 8'h0c;
  localparam logic [7:0] OFS_T1LIM  = 8'h10;
  localparam logic [7:0] OFS_SDLIM  = 8'h14;
  localparam logic [7:0] OFS_C0LIM  = 8'h18;
  localparam logic [7:0] OFS_C1LIM  = 8'h1c;
  localparam logic [7:0] OFS_ADJ    = 8'h20;
  localparam logic [7:0] OFS_CTRL   = 8'h24;

  // Register indices
  localparam logic [3:0] IDX_BTE_LO = 4'h0;
  localparam logic [3:0] IDX_BTE_HI = 4'h1;
  localparam logic [3:0] IDX_HOLD   = 4'h2;
  localparam logic [3:0] IDX_T0LIM  = 4'h3;
  localparam logic [3:0] IDX_T1LIM  = 4'h4;
  localparam logic [3:0] IDX_SDLIM  = 4'h5;
  localparam logic [3:0] IDX_C0LIM  = 4'h6;
  localparam logic [3:0] IDX_C1LIM  = 4'h7;
  localparam logic [3:0] IDX_ADJ    = 4'h8;
  localparam logic [3:0] IDX_CTRL   = 4'h9;

  // Control register fields
  localparam int unsigned CTRL_VIS_BIT  = 0;
  localparam int unsigned CTRL_BUSY_BIT = 1;

  localparam logic [15:0] DATA_RST  = 16'h0000;
  localparam logic [4:0]  QPTR_STEP = 5'h01;

  typedef enum logic [2:0] {
    TSQ_CMD_NONE  = 3'h0,
    TSQ_CMD_COPY  = 3'h1,
    TSQ_CMD_ADD   = 3'h2,
    TSQ_CMD_JMPC0 = 3'h3,
    TSQ_CMD_JMPC1 = 3'h4,
    TSQ_CMD_BCAST = 3'h5
  } tsq_cmd_type;

  typedef enum logic [2:0] {
    TSQ_TGT_T0  = 3'h0,
    TSQ_TGT_T1  = 3'h1,
    TSQ_TGT_SD  = 3'h2,
    TSQ_TGT_C0  = 3'h3,
    TSQ_TGT_C1  = 3'h4,
    TSQ_TGT_LIT = 3'h5
  } tsq_tgt_type;

  typedef enum logic [1:0] {
    TSQ_ST_IDLE = 2'b01,
    TSQ_ST_ACK  = 2'b10
  } tsq_state_type;
endpackage

// ==== hw/tsq_cnt_if.sv ====
`timescale 1ns/1ps
interface tsq_cnt_if;
  logic        step;
  logic        clear;
  logic [15:0] limit;
  logic [15:0] count;
  logic        at_limit;
  modport ctl (output step, output clear, output limit, input count, input at_limit);
  modport cnt (input step, input clear, input limit, output count, output at_limit);
endinterface

// ==== hw/tsq_loop_counter.sv ====
`timescale 1ns/1ps
module tsq_loop_counter
(
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  // Counter link
  tsq_cnt_if.cnt    cnt_bus
);
  assign cnt_bus.at_limit = (cnt_bus.count == cnt_bus.limit);

  // Count up on a jump while below limit
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in || cnt_bus.clear)
      cnt_bus.count <= tsq_pkg::DATA_RST;
    else if (cnt_bus.step && !cnt_bus.at_limit)
      cnt_bus.count <= 16'(cnt_bus.count + 16'h0001);
  end

  a_cnt_step_inc : assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    cnt_bus.step && !cnt_bus.at_limit && !cnt_bus.clear |=> cnt_bus.count == $past(cnt_bus.count) + 16'h0001)
    else $error("loop counter did not increment below limit");
  a_cnt_hold_lim : assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    cnt_bus.step && cnt_bus.at_limit && !cnt_bus.clear |=> $stable(cnt_bus.count))
    else $error("loop counter moved at limit");
endmodule

// ==== hw/tsq_bcast_trig.sv ====
`timescale 1ns/1ps
module tsq_bcast_trig
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // Broadcast request
  input  wire logic        fire_in,
  input  wire logic [31:0] mask_in,
  // Trigger outputs
  output logic      [31:0] trig_out
);
  genvar g;
  generate
    for (g = 0; g < tsq_pkg::MASK_W; g++)
    begin : g_bit
      always_ff @(posedge ref_clk_in)
      begin
        if (sys_rst_in)
          trig_out[g] <= 1'b0;
        else
          trig_out[g] <= fire_in && mask_in[g];
      end
    end
  endgenerate

  a_bcast_mask : assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    fire_in |=> trig_out == $past(mask_in))
    else $error("broadcast triggers differ from mask");
  a_bcast_quiet : assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !fire_in |=> trig_out == 32'h0000_0000)
    else $error("trigger without broadcast");
endmodule

// ==== tb/tb_tsq_data_regs.sv ====
`timescale 1ns/1ps
module tb_tsq_data_regs;
  typedef struct packed
  {
    logic [31:0] data;
    logic        err;
    logic        rd;
  } tsq_note_type;

  logic         ref_clk_in;
  logic         sys_rst_in;
  logic  [7:0]  paddr_in;
  logic         psel_in;
  logic         penable_in;
  logic         pwrite_in;
  logic  [31:0] pwdata_in;
  logic  [31:0] prdata_out;
  logic         pready_out;
  logic         pslverr_out;
  logic         seq_busy_in;
  logic         cmd_valid_in;
  logic  [2:0]  cmd_op_in;
  logic  [2:0]  cmd_target_in;
  logic  [4:0]  jump_target_in;
  logic  [4:0]  queue_pointer_in;
  logic  [15:0] timer0_count_in;
  logic  [15:0] timer1_count_in;
  logic  [15:0] step_delay_count_in;
  logic  [31:0] broadcast_trig_out;
  logic         queue_pointer_load_out;
  logic  [4:0]  queue_pointer_next_out;
  logic  [15:0] timer0_limit_out;
  logic  [15:0] timer1_limit_out;
  logic  [15:0] step_delay_limit_out;
  logic  [15:0] counter0_limit_out;
  logic  [15:0] counter1_limit_out;
  logic  [15:0] literal_register_out;
  logic  [15:0] loop_counter0_out;
  logic  [15:0] loop_counter1_out;
  logic  [15:0] mdl [9];
  tsq_note_type apb_q [$];
  logic  [4:0]  qp_q [$];
  logic  [31:0] trig_q [$];
  tsq_note_type n_note;
  logic  [15:0] cnt;
  int           mismatches;
  int           cmp_count;

  tsq_data_regs i_dut
  (
    .ref_clk_in             (ref_clk_in),
    .sys_rst_in             (sys_rst_in),
    .paddr_in               (paddr_in),
    .psel_in                (psel_in),
    .penable_in             (penable_in),
    .pwrite_in              (pwrite_in),
    .pwdata_in              (pwdata_in),
    .prdata_out             (prdata_out),
    .pready_out             (pready_out),
    .pslverr_out            (pslverr_out),
    .seq_busy_in            (seq_busy_in),
    .cmd_valid_in           (cmd_valid_in),
    .cmd_op_in              (cmd_op_in),
    .cmd_target_in          (cmd_target_in),
    .jump_target_in         (jump_target_in),
    .queue_pointer_in       (queue_pointer_in),
    .timer0_count_in        (timer0_count_in),
    .timer1_count_in        (timer1_count_in),
    .step_delay_count_in    (step_delay_count_in),
    .broadcast_trig_out     (broadcast_trig_out),
    .queue_pointer_load_out (queue_pointer_load_out),
    .queue_pointer_next_out (queue_pointer_next_out),
    .timer0_limit_out       (timer0_limit_out),
    .timer1_limit_out       (timer1_limit_out),
    .step_delay_limit_out   (step_delay_limit_out),
    .counter0_limit_out     (counter0_limit_out),
    .counter1_limit_out     (counter1_limit_out),
    .literal_register_out   (literal_register_out),
    .loop_counter0_out      (loop_counter0_out),
    .loop_counter1_out      (loop_counter1_out)
  );

  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; the expected answer is noted first
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd, input logic [31:0] exp,
                     input logic err);
    int k;
    apb_q.push_back(tsq_note_type'{data: exp, err: err, rd: ~wr});
    @(posedge ref_clk_in);
    paddr_in   <= a;
    pwrite_in  <= wr;
    pwdata_in  <= wd;
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk_in);
      k++;
    end
    while (pready_out !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      cmp(32'h0, 32'h1, "no ready");
      print_verdict();
    end
    else
    begin
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask

  task automatic wr_reg(input int i, input logic [31:0] d);
    apb(8'(i * 4), 1'b1, d, 32'h0, 1'b0);
    if (seq_busy_in !== 1'b1)
    begin
      mdl[i] = d[15:0];
    end
  endtask

  task automatic chk_reg(input int i);
    apb(8'(i * 4), 1'b0, 32'h0, {16'h0000, mdl[i]}, 1'b0);
  endtask

  task automatic cmd(input logic [2:0] op, input logic [2:0] tgt);
    @(posedge ref_clk_in);
    cmd_valid_in  <= 1'b1;
    cmd_op_in     <= op;
    cmd_target_in <= tgt;
    @(posedge ref_clk_in);
    cmd_valid_in  <= 1'b0;
  endtask

  // Result watcher: oldest note against each answer
  always @(posedge ref_clk_in)
  begin
    if (pready_out === 1'b1)
    begin
      n_note = apb_q.pop_front();
      cmp({31'h0, pslverr_out}, {31'h0, n_note.err}, "slave error");
      if (n_note.rd)
      begin
        cmp(prdata_out, n_note.data, "read data");
      end
    end
    if (queue_pointer_load_out === 1'b1)
    begin
      cmp({27'h0, queue_pointer_next_out}, {27'h0, qp_q.pop_front()}, "queue pointer");
    end
    if (sys_rst_in === 1'b0 && broadcast_trig_out !== 32'h0)
    begin
      cmp(broadcast_trig_out, trig_q.pop_front(), "broadcast");
    end
  end

  initial
  begin
    sys_rst_in = 1'b1;
    paddr_in = 8'h00;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    pwdata_in = 32'h0;
    seq_busy_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_op_in = 3'h0;
    cmd_target_in = 3'h0;
    jump_target_in = 5'h00;
    queue_pointer_in = 5'h00;
    timer0_count_in = 16'h0000;
    timer1_count_in = 16'h0000;
    step_delay_count_in = 16'h0000;
    mismatches = 0;
    cmp_count = 0;
    for (int i = 0; i < 9; i++) mdl[i] = 16'h0000;
    void'($urandom(14));
    repeat (3) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 9; i++) chk_reg(i);
    apb(8'h28, 1'b0, 32'h0, 32'h0, 1'b1);
    apb(8'h28, 1'b1, $urandom, 32'h0, 1'b1);
    $display("test reset and unmapped done");
    for (int i = 0; i < 9; i++)
    begin
      wr_reg(i, $urandom | 32'h1);
      chk_reg(i);
    end
    $display("test read write done");
    @(posedge ref_clk_in);
    seq_busy_in <= 1'b1;
    trig_q.push_back({mdl[1], mdl[0]});
    cmd(tsq_pkg::TSQ_CMD_BCAST, 3'h0);
    $display("test broadcast done");
    for (int t = 0; t < 6; t++)
    begin
      cmd(tsq_pkg::TSQ_CMD_COPY, 3'(t));
      if (t < 5)
      begin
        mdl[3 + t] = mdl[2];
        chk_reg(3 + t);
      end
    end
    @(posedge ref_clk_in);
    cmp({16'h0, literal_register_out}, {16'h0, mdl[2]}, "literal copy");
    for (int t = 0; t < 6; t++)
    begin
      cmd(tsq_pkg::TSQ_CMD_ADD, 3'(t));
      if (t < 5)
      begin
        mdl[3 + t] = mdl[3 + t] + mdl[8];
        chk_reg(3 + t);
      end
    end
    @(posedge ref_clk_in);
    cmp({16'h0, literal_register_out}, {16'h0, 16'(mdl[2] + mdl[8])}, "literal add");
    cmp({timer0_limit_out, timer1_limit_out}, {mdl[3], mdl[4]}, "timer limits");
    cmp({step_delay_limit_out, counter0_limit_out}, {mdl[5], mdl[6]}, "delay and counter0 limits");
    cmp({16'h0, counter1_limit_out}, {16'h0, mdl[7]}, "counter1 limit");
    $display("test copy and add done");
    for (int i = 0; i < 9; i++)
    begin
      wr_reg(i, {16'h0, ~mdl[i]});
      chk_reg(i);
    end
    $display("test busy writes done");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge ref_clk_in);
      seq_busy_in <= 1'b0;
      wr_reg(6 + k, 32'h2);
      @(posedge ref_clk_in);
      seq_busy_in <= 1'b1;
      jump_target_in <= 5'($urandom);
      queue_pointer_in <= 5'($urandom);
      timer0_count_in <= 16'($urandom);
      timer1_count_in <= 16'($urandom);
      step_delay_count_in <= 16'($urandom);
      @(posedge ref_clk_in);
      cnt = 16'h0;
      repeat (4)
      begin
        if (cnt != 16'h2)
        begin
          qp_q.push_back(jump_target_in);
          cnt++;
        end
        else
        begin
          qp_q.push_back(5'(queue_pointer_in + 5'h01));
        end
        cmd(3'(tsq_pkg::TSQ_CMD_JMPC0 + k), 3'h0);
      end
      cmp({16'h0, (k == 0) ? loop_counter0_out : loop_counter1_out}, 32'h2, "loop count");
      apb(tsq_pkg::OFS_CTRL, 1'b1, 32'h1, 32'h0, 1'b0);
      apb(tsq_pkg::OFS_CTRL, 1'b0, 32'h0, 32'h3, 1'b0);
      apb(tsq_pkg::OFS_T0LIM, 1'b0, 32'h0, {16'h0, timer0_count_in}, 1'b0);
      apb(tsq_pkg::OFS_T1LIM, 1'b0, 32'h0, {16'h0, timer1_count_in}, 1'b0);
      apb(tsq_pkg::OFS_SDLIM, 1'b0, 32'h0, {16'h0, step_delay_count_in}, 1'b0);
      apb(8'(24 + 4 * k), 1'b0, 32'h0, {16'h0, cnt}, 1'b0);
      apb(tsq_pkg::OFS_CTRL, 1'b1, 32'h0, 32'h0, 1'b0);
      chk_reg(6 + k);
    end
    $display("test jumps and visibility done");
    repeat (3) @(posedge ref_clk_in);
    cmp(32'(apb_q.size() + qp_q.size() + trig_q.size()), 32'h0, "answers missing");
    print_verdict();
  end
endmodule
